// >>> hw/flash_wp_pkg.sv
/*
 * Shared constants and carrier types of the flash write-protection gate:
 * register offsets, field positions, reset values, command codes and structs.
 * Assumes a command decoder in front of the gate that hands over one decoded
 * flash command at a time, and an APB master that reaches the registers.
 */
package flash_wp_pkg;

   // Geometry of the array and of the protection table, APB address width and counter width.
   localparam int ADDR_W    = 24;
   localparam int SECTOR_W  = 12;
   localparam int BP_W      = 4;
   localparam int N_CODES   = 16;
   localparam int PADDR_W   = 12;
   localparam int CNT_W     = 16;

   // Register byte offsets.
   localparam logic [PADDR_W-1:0] OFS_STATUS     = 12'h000;
   localparam logic [PADDR_W-1:0] OFS_DISCARDS   = 12'h004;
   localparam logic [PADDR_W-1:0] OFS_PINS       = 12'h008;
   localparam logic [PADDR_W-1:0] OFS_RANGE_BASE = 12'h040;
   localparam logic [PADDR_W-1:0] OFS_RANGE_LAST = 12'h07c;

   // Field positions of a range word and of the pin word.
   localparam int RANGE_EN_POS = 31;
   localparam int RANGE_HI_LSB = 16;
   localparam int RANGE_LO_LSB = 0;
   localparam int PIN_WP_POS   = 0;
   localparam int PIN_LOCK_POS = 1;

   // Reset values.
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [24:0] RANGE_RST  = 25'h0000000;

   // Decoded flash commands seen by the gate.
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_SET_LATCH,
      CMD_CLEAR_LATCH,
      CMD_WRITE_STATUS,
      CMD_PROGRAM,
      CMD_ERASE,
      CMD_CHIP_ERASE
   } cmd_op_t;

   // Status byte, most significant bit first.
   typedef struct packed {
      logic            status_lock_bit;
      logic            quad_io_enable_bit;
      logic [BP_W-1:0] block_protect_bits;
      logic            write_enable_latch;
      logic            reserved;
   } status_t;

   // One entry of the protection table, in sector units.
   typedef struct packed {
      logic                en;
      logic [SECTOR_W-1:0] hi;
      logic [SECTOR_W-1:0] lo;
   } range_entry_t;

   typedef range_entry_t [N_CODES-1:0] range_table_t;

   // Command handed over by the decoder.
   typedef struct packed {
      logic              valid;
      cmd_op_t           op;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } cmd_req_t;

   // Command passed on to the array engine.
   typedef struct packed {
      logic              valid;
      cmd_op_t           op;
      logic [ADDR_W-1:0] addr;
   } exec_t;

endpackage : flash_wp_pkg

// >>> hw/flash_wp_range_lookup.sv
/*
 * Combinational lookup that tells whether an address, or the whole array,
 * falls inside the region that the current block protect code selects.
 * Assumes the table is held in flip-flops by the instantiating module.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_wp_range_lookup #(
   parameter int ADDR_W   = flash_wp_pkg::ADDR_W,
   parameter int SECTOR_W = flash_wp_pkg::SECTOR_W
) (
   input  wire flash_wp_pkg::range_table_t        ranges_i,
   input  wire logic [flash_wp_pkg::BP_W-1:0]     code_i,
   input  wire logic [ADDR_W-1:0]                 addr_i,
   input  wire logic                              whole_i,
   output logic                                   hit_o
);

   flash_wp_pkg::range_entry_t entry;
   logic [SECTOR_W-1:0]        sector;

   // Code zero leaves the array open; a whole-array erase is blocked by any
   // other code, even one whose table entry is disabled and protects nothing.
   always_comb begin
      entry  = ranges_i[code_i];
      sector = addr_i[ADDR_W-1 -: SECTOR_W];
      if (code_i == '0) begin
         hit_o = 1'b0;
      end else if (whole_i) begin
         hit_o = 1'b1;
      end else begin
         hit_o = entry.en && (sector >= entry.lo) && (sector <= entry.hi);
      end
   end

endmodule : flash_wp_range_lookup

`default_nettype wire

// >>> hw/flash_wp_gate.sv
/*
 * Write-protection gate of a serial flash: keeps the status byte and the
 * write enable latch, filters program, erase and status writes, and offers
 * the protection table and discard counter to software over APB (zero wait states).
 * Assumes commands arrive decoded, one per valid cycle, synchronous to clk_i,
 * and that the write-protect pin level is already synchronous to clk_i.
 */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module flash_wp_gate #(
   parameter int CNT_W = flash_wp_pkg::CNT_W
) (
   input  wire logic                                 clk_i,
   input  wire logic                                 rst_n_i,
   // APB slave.
   input  wire logic                                 psel_i,
   input  wire logic                                 penable_i,
   input  wire logic                                 pwrite_i,
   input  wire logic [flash_wp_pkg::PADDR_W-1:0]     paddr_i,
   input  wire logic [31:0]                          pwdata_i,
   output logic [31:0]                               prdata_o,
   output logic                                      pready_o,
   output logic                                      pslverr_o,
   // Pin and command side.
   input  wire logic                                 wp_n_i,
   input  wire flash_wp_pkg::cmd_req_t               cmd_i,
   output flash_wp_pkg::exec_t                       exec_o,
   output logic                                      refuse_o,
   output flash_wp_pkg::status_t                     status_o
);

   // Whole state of the gate in one record.
   typedef struct packed {
      flash_wp_pkg::status_t      status;
      flash_wp_pkg::range_table_t ranges;
      logic [CNT_W-1:0]           discards;
      flash_wp_pkg::exec_t        exec;
      logic                       refuse;
      logic [31:0]                rdata;
      logic                       slverr;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic   prot_hit;
   logic   status_locked;
   logic   apb_setup;
   logic   apb_write;
   logic   is_write_op;
   logic   is_array_op;

   // True for an aligned offset inside the protection table window.
   function automatic logic is_range(input logic [flash_wp_pkg::PADDR_W-1:0] a);
      return (a >= flash_wp_pkg::OFS_RANGE_BASE) && (a <= flash_wp_pkg::OFS_RANGE_LAST) && (a[1:0] == 2'h0);
   endfunction : is_range

   // True for any offset that the map answers.
   function automatic logic is_mapped(input logic [flash_wp_pkg::PADDR_W-1:0] a);
      return (a == flash_wp_pkg::OFS_STATUS) || (a == flash_wp_pkg::OFS_DISCARDS) ||
             (a == flash_wp_pkg::OFS_PINS) || is_range(a);
   endfunction : is_mapped

   // Packs a table entry into its register word.
   function automatic logic [31:0] range_word(input flash_wp_pkg::range_entry_t e);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[flash_wp_pkg::RANGE_EN_POS] = e.en;
      w[flash_wp_pkg::RANGE_HI_LSB +: flash_wp_pkg::SECTOR_W] = e.hi;
      w[flash_wp_pkg::RANGE_LO_LSB +: flash_wp_pkg::SECTOR_W] = e.lo;
      return w;
   endfunction : range_word

   // Qualifiers shared by the next-state logic and the checks below.
   assign apb_setup     = psel_i && !penable_i;
   assign apb_write     = psel_i && penable_i && pwrite_i;
   assign status_locked = state_reg.status.status_lock_bit && !wp_n_i;
   assign is_array_op   = (cmd_i.op == flash_wp_pkg::CMD_PROGRAM) || (cmd_i.op == flash_wp_pkg::CMD_ERASE) ||
                          (cmd_i.op == flash_wp_pkg::CMD_CHIP_ERASE);
   assign is_write_op   = is_array_op || (cmd_i.op == flash_wp_pkg::CMD_WRITE_STATUS);

   // Address check against the region of the current protect code.
   flash_wp_range_lookup #(
      .ADDR_W   (flash_wp_pkg::ADDR_W),
      .SECTOR_W (flash_wp_pkg::SECTOR_W)
   ) u_lookup (
      .ranges_i (state_reg.ranges),
      .code_i   (state_reg.status.block_protect_bits),
      .addr_i   (cmd_i.addr),
      .whole_i  (cmd_i.op == flash_wp_pkg::CMD_CHIP_ERASE),
      .hit_o    (prot_hit)
   );

   // Next state: APB side first, then the command filter.  A refused command
   // counted in the same cycle as a software clear of the counter still
   // counts, so the counter then reads one.
   always_comb begin
      logic                    refuse;
      logic                    clear_cnt;
      flash_wp_pkg::status_t   wr;
      refuse     = 1'b0;
      clear_cnt  = 1'b0;
      wr         = flash_wp_pkg::status_t'(cmd_i.data);
      state_next = state_reg;
      state_next.exec.valid = 1'b0;
      state_next.refuse     = 1'b0;

      // Read data is captured in the setup cycle so that it comes from a
      // flip-flop while pready is already high in the access cycle.
      if (apb_setup) begin
         state_next.slverr = !is_mapped(paddr_i);
         state_next.rdata  = 32'h0000_0000;
         if (!pwrite_i) begin
            if (paddr_i == flash_wp_pkg::OFS_STATUS) begin
               state_next.rdata[7:0] = state_reg.status;
            end else if (paddr_i == flash_wp_pkg::OFS_DISCARDS) begin
               state_next.rdata[CNT_W-1:0] = state_reg.discards;
            end else if (paddr_i == flash_wp_pkg::OFS_PINS) begin
               state_next.rdata[flash_wp_pkg::PIN_WP_POS]   = wp_n_i;
               state_next.rdata[flash_wp_pkg::PIN_LOCK_POS] = status_locked;
            end else if (is_range(paddr_i)) begin
               state_next.rdata = range_word(state_reg.ranges[paddr_i[5:2]]);
            end
         end
      end

      // Writes take effect in the access cycle; status and pins are read-only.
      if (apb_write) begin
         if (is_range(paddr_i)) begin
            state_next.ranges[paddr_i[5:2]].en = pwdata_i[flash_wp_pkg::RANGE_EN_POS];
            state_next.ranges[paddr_i[5:2]].hi = pwdata_i[flash_wp_pkg::RANGE_HI_LSB +: flash_wp_pkg::SECTOR_W];
            state_next.ranges[paddr_i[5:2]].lo = pwdata_i[flash_wp_pkg::RANGE_LO_LSB +: flash_wp_pkg::SECTOR_W];
         end
         if (paddr_i == flash_wp_pkg::OFS_DISCARDS) begin
            clear_cnt = 1'b1;
         end
      end

      // Command filter.
      if (cmd_i.valid) begin
         unique case (cmd_i.op)
            flash_wp_pkg::CMD_SET_LATCH: begin
               state_next.status.write_enable_latch = 1'b1;
            end
            flash_wp_pkg::CMD_CLEAR_LATCH: begin
               state_next.status.write_enable_latch = 1'b0;
            end
            flash_wp_pkg::CMD_WRITE_STATUS: begin
               if (!state_reg.status.write_enable_latch) begin
                  refuse = 1'b1;
               end else if (status_locked) begin
                  refuse = 1'b1;
                  state_next.status.write_enable_latch = 1'b0;
               end else begin
                  state_next.status.status_lock_bit    = wr.status_lock_bit;
                  state_next.status.quad_io_enable_bit = wr.quad_io_enable_bit;
                  state_next.status.block_protect_bits = wr.block_protect_bits;
                  state_next.status.write_enable_latch = 1'b0;
               end
            end
            flash_wp_pkg::CMD_PROGRAM, flash_wp_pkg::CMD_ERASE, flash_wp_pkg::CMD_CHIP_ERASE: begin
               if (!state_reg.status.write_enable_latch) begin
                  refuse = 1'b1;
               end else if (prot_hit) begin
                  refuse = 1'b1;
                  state_next.status.write_enable_latch = 1'b0;
               end else begin
                  state_next.exec.valid = 1'b1;
                  state_next.exec.op    = cmd_i.op;
                  state_next.exec.addr  = cmd_i.addr;
                  state_next.status.write_enable_latch = 1'b0;
               end
            end
            default: begin
               state_next.status = state_reg.status;
            end
         endcase
      end

      // Discard counter saturates rather than wrapping, so a flood of
      // refused commands never makes it look quiet again.
      if (clear_cnt) begin
         state_next.discards = '0;
      end
      if (refuse && (state_next.discards != '1)) begin
         state_next.discards = state_next.discards + CNT_W'(1);
      end
      state_next.refuse = refuse;
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg.status   <= flash_wp_pkg::STATUS_RST;
         state_reg.ranges   <= {flash_wp_pkg::N_CODES{flash_wp_pkg::RANGE_RST}};
         state_reg.discards <= '0;
         state_reg.exec     <= '0;
         state_reg.refuse   <= 1'b0;
         state_reg.rdata    <= 32'h0000_0000;
         state_reg.slverr   <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs; the bus never inserts wait states.
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && state_reg.slverr;
   assign prdata_o  = state_reg.rdata;
   assign exec_o    = state_reg.exec;
   assign refuse_o  = state_reg.refuse;
   assign status_o  = state_reg.status;

   // Helper for the table check: table index of the current bus address.
   logic [3:0] wr_idx;
   assign wr_idx = paddr_i[5:2];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_LOCK_HOLDS: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_WRITE_STATUS && status_locked)
      |=> $stable(status_o.block_protect_bits) && $stable(status_o.status_lock_bit)
          && $stable(status_o.quad_io_enable_bit) && refuse_o)
      else $error("Protected status bits changed while locked.");

   AST_STATUS_WRITE: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_WRITE_STATUS && !status_locked
       && status_o.write_enable_latch)
      |=> (status_o[7:2] == $past(cmd_i.data[7:2])) && !status_o.write_enable_latch && !refuse_o)
      else $error("Unlocked status write did not take effect.");

   AST_NO_LATCH_DROP: assert property (
      (cmd_i.valid && is_write_op && !status_o.write_enable_latch)
      |=> refuse_o && !exec_o.valid && $stable(status_o))
      else $error("Write command without latch was not dropped.");

   AST_PROTECT_BLOCK: assert property (
      (cmd_i.valid && is_array_op && status_o.write_enable_latch && prot_hit)
      |=> refuse_o && !exec_o.valid)
      else $error("Program or erase into protected region went through.");

   AST_OPEN_EXEC: assert property (
      (cmd_i.valid && is_array_op && status_o.write_enable_latch && !prot_hit)
      |=> exec_o.valid && (exec_o.addr == $past(cmd_i.addr)) ##1 !exec_o.valid)
      else $error("Open program or erase was not passed on for one cycle.");

   AST_TABLE_WRITE: assert property (
      (apb_write && is_range(paddr_i))
      |=> (state_reg.ranges[$past(wr_idx)].en == $past(pwdata_i[31]))
          && (range_word(state_reg.ranges[$past(wr_idx)]) == ($past(pwdata_i) & 32'h8fff_0fff)))
      else $error("Protection table entry did not take the written value.");

   // Latch, counter and read-back checks.  A latch that failed to clear would
   // let a second write through on one set-latch command, so it is watched after
   // clear-latch commands and after locked and completed status writes.
   AST_LATCH_SET: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_SET_LATCH)
      |=> status_o.write_enable_latch)
      else $error("Set-latch command did not set the write enable latch.");

   AST_LATCH_CLEAR: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_CLEAR_LATCH)
      |=> !status_o.write_enable_latch && !refuse_o && !exec_o.valid)
      else $error("Clear-latch command left the latch set or gave an answer.");

   AST_LOCK_DROPS_LATCH: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_WRITE_STATUS && status_locked
       && status_o.write_enable_latch)
      |=> !status_o.write_enable_latch)
      else $error("Locked status write left the write enable latch set.");

   AST_ONE_ANSWER: assert property (
      !(refuse_o && exec_o.valid))
      else $error("A command was both refused and passed on.");

   AST_EXEC_HAS_CMD: assert property (
      exec_o.valid
      |-> $past(cmd_i.valid) && $past(is_array_op) && $past(status_o.write_enable_latch))
      else $error("Program or erase passed on without a latched command.");

   AST_CHIP_ERASE_BLOCK: assert property (
      (cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_CHIP_ERASE && (status_o.block_protect_bits != '0))
      |=> !exec_o.valid)
      else $error("Whole-array erase went through with a protect code set.");

   AST_STATUS_QUIET: assert property (
      !(cmd_i.valid && cmd_i.op == flash_wp_pkg::CMD_WRITE_STATUS)
      |=> $stable(status_o[7:2]))
      else $error("Protection or lock bits changed without a status write.");

   AST_REFUSE_COUNTS: assert property (
      (cmd_i.valid && is_write_op && !status_o.write_enable_latch && !apb_write
       && (state_reg.discards != '1))
      |=> state_reg.discards == $past(state_reg.discards) + CNT_W'(1))
      else $error("A dropped command was not counted.");

   AST_PIN_READ: assert property (
      (apb_setup && !pwrite_i && paddr_i == flash_wp_pkg::OFS_PINS)
      |=> prdata_o[flash_wp_pkg::PIN_LOCK_POS] == $past(status_locked))
      else $error("Pin word did not show the lock state.");

endmodule : flash_wp_gate

`default_nettype wire

// >>> tb/flash_wp_host_model.sv
/*
 * Partner model of the host side: stands in for the host controller and its
 * command decoder, handing one decoded flash command at a time to the gate.
 * Assumes the gate samples cmd_o on rising edges of clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_wp_host_model (
   input  wire logic                   clk_i,
   output var flash_wp_pkg::cmd_req_t  cmd_o
);

   // The bus starts at zero; a released bus clears valid and op and shows inverted address and data, so a stale command cannot pass for a live one.
   initial cmd_o = '0;

   // One command, valid for exactly one cycle; outputs of the gate are settled on return.
   task automatic issue(input flash_wp_pkg::cmd_op_t op, input logic [23:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cmd_o <= '{valid: 1'b1, op: op, addr: a, data: d};
      @(posedge clk_i);
      cmd_o <= '{valid: 1'b0, op: flash_wp_pkg::CMD_NONE, addr: ~a, data: ~d};
      #1;
   endtask : issue

   // Each program, erase or status write is preceded by the latch command.
   task automatic issue_latched(input flash_wp_pkg::cmd_op_t op, input logic [23:0] a, input logic [7:0] d);
      issue(flash_wp_pkg::CMD_SET_LATCH, ~a, ~d);
      issue(op, a, d);
   endtask : issue_latched

endmodule : flash_wp_host_model

`default_nettype wire

// >>> tb/flash_wp_gate_tb_top.sv
/*
 * Self-checking testbench of the write-protection gate: random and corner
 * status writes, protected-range program and erase, and APB register access.
 * Assumes the zero-wait APB slave and one-cycle command answer of the gate.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_wp_gate_tb_top;
   logic                   clk_i;
   logic                   rst_n_i;
   logic                   psel_i;
   logic                   penable_i;
   logic                   pwrite_i;
   logic [11:0]            paddr_i;
   logic [31:0]            pwdata_i;
   logic [31:0]            prdata_o;
   logic                   pready_o;
   logic                   pslverr_o;
   logic                   wp_n_i;
   flash_wp_pkg::cmd_req_t cmd_i;
   flash_wp_pkg::exec_t    exec_o;
   logic                   refuse_o;
   flash_wp_pkg::status_t  status_o;
   int                     failures;
   int                     num_checks;
   int                     disc;
   integer                 seed;
   logic [5:0]             st;
   logic [31:0]            rd;
   logic                   err;
   logic                   w;
   logic                   lk;
   logic [7:0]             d;
   logic [23:0]            a;
   flash_wp_pkg::cmd_op_t  op;

   flash_wp_gate flash_wp_gate_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .wp_n_i(wp_n_i), .cmd_i(cmd_i), .exec_o(exec_o), .refuse_o(refuse_o),
      .status_o(status_o));

   flash_wp_host_model flash_wp_host_model_inst (.clk_i(clk_i), .cmd_o(cmd_i));

   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One APB transfer; the wait for pready is bounded rather than assumed.
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= ad;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (pready_o !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   // Issues a command and compares the answer; refusals are tallied for the counter.
   task automatic cmd(input flash_wp_pkg::cmd_op_t o, input logic [23:0] ad, input logic [7:0] dd,
                      input logic latched, input logic exp_ref, input logic [5:0] exp_st);
      if (latched) flash_wp_host_model_inst.issue_latched(o, ad, dd);
      else flash_wp_host_model_inst.issue(o, ad, dd);
      check("refuse", {31'h0, refuse_o}, {31'h0, exp_ref});
      check("status", {26'h0, status_o[7:2]}, {26'h0, exp_st});
      if (o >= flash_wp_pkg::CMD_PROGRAM) begin
         check("exec", {31'h0, exec_o.valid}, {31'h0, !exp_ref});
         if (!exp_ref) check("exec_addr", {5'h0, exec_o.op, exec_o.addr}, {5'h0, o, ad});
      end
      disc += exp_ref;
   endtask : cmd

   // Only code 3 has an enabled range; any nonzero code blocks chip erase.
   function automatic logic blocked(input flash_wp_pkg::cmd_op_t o, input logic [23:0] ad);
      if (st[3:0] == 4'h0) return 1'b0;
      if (o == flash_wp_pkg::CMD_CHIP_ERASE) return 1'b1;
      return st[3:0] == 4'h3 && ad[23:12] >= 12'h010 && ad[23:12] <= 12'h01f;
   endfunction : blocked

   // Main sequence.
   initial begin
      seed = 32'h4226;
      {failures, num_checks, disc} = '0;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      wp_n_i = 1'b1;
      rst_n_i = 1'b0;
      st = '0;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check("status_rst", {24'h0, status_o}, 32'h0);
      check("exec_rst", {31'h0, exec_o.valid | refuse_o}, 32'h0);
      for (int i = 3; i <= 6; i++) cmd(flash_wp_pkg::cmd_op_t'(i), 24'h010000, 8'hfc, 1'b0, 1'b1, st);
      flash_wp_host_model_inst.issue(flash_wp_pkg::CMD_SET_LATCH, 24'h0, 8'h0);
      check("latch", {31'h0, status_o.write_enable_latch}, 32'h1);
      flash_wp_host_model_inst.issue(flash_wp_pkg::CMD_CLEAR_LATCH, 24'h0, 8'h0);
      check("latch_clr", {31'h0, status_o.write_enable_latch}, 32'h0);
      cmd(flash_wp_pkg::CMD_WRITE_STATUS, 24'h0, 8'hfc, 1'b0, 1'b1, st);
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_i);
         w = (i < 4) ? i[1] : $random(seed);
         wp_n_i <= w;
         d = (i < 4) ? 8'hff : $random(seed);
         lk = st[5] & !w;
         cmd(flash_wp_pkg::CMD_WRITE_STATUS, 24'h0, d, 1'b1, lk, lk ? st : d[7:2]);
         st = lk ? st : d[7:2];
         apb(1'b0, flash_wp_pkg::OFS_PINS, 32'h0);
         check("pins", rd, {30'h0, st[5] & !w, w});
      end
      @(posedge clk_i);
      wp_n_i <= 1'b1;
      cmd(flash_wp_pkg::CMD_WRITE_STATUS, 24'h0, 8'h00, 1'b1, 1'b0, 6'h00);
      apb(1'b1, 12'h04c, 32'h801f0010);
      apb(1'b0, 12'h04c, 32'h0);
      check("range3", rd, 32'h801f0010);
      apb(1'b0, 12'h054, 32'h0);
      check("range5", rd, 32'h0);
      for (int c = 3; c <= 5; c += 2) begin
         st = 6'(c);
         cmd(flash_wp_pkg::CMD_WRITE_STATUS, 24'h0, 8'(c << 2), 1'b1, 1'b0, st);
         for (int i = 0; i < 20; i++) begin
            a = (i < 4) ? {12'h00f + 12'(i[1:0] * 1 + (i > 1 ? 14 : 0)), 12'h000} : {6'h0, 18'($random(seed))};
            op = flash_wp_pkg::cmd_op_t'(4 + (i < 4 ? 0 : ($random(seed) & 3) % 3));
            cmd(op, a, 8'h00, 1'b1, blocked(op, a), st);
         end
      end
      apb(1'b0, flash_wp_pkg::OFS_DISCARDS, 32'h0);
      check("discards", rd, 32'(disc));
      apb(1'b1, flash_wp_pkg::OFS_DISCARDS, 32'h0);
      apb(1'b0, flash_wp_pkg::OFS_DISCARDS, 32'h0);
      check("discards_clr", rd, 32'h0);
      apb(1'b1, flash_wp_pkg::OFS_STATUS, 32'hff);
      apb(1'b0, flash_wp_pkg::OFS_STATUS, 32'h0);
      check("status_ro", {24'h0, rd[7:2], 2'h0}, {24'h0, st, 2'h0});
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      tally_and_finish();
   end

endmodule : flash_wp_gate_tb_top

`default_nettype wire
